// File: hw/hfo_defs.svh
/*
  Offsets, field positions, reset values and timing counts of the HDLC
  frame options block. Assumes byte addresses on a 32-bit Wishbone bus.
*/
// Functional notes
// R1 - crc forwarding puts two crc bytes in fifo
// R2 - status byte follows the forwarded crc bytes
// R3 - received crc is always checked and reported
// R4 - host crc mode: no internal crc appended
// R5 - host writes crc as last two bytes
// R6 - host crc mode still closes with flag
// R7 - idle fill: ones or repeated flags
// R8 - threshold picks block of 32/16/4/2 bytes
// R9 - pool full reports exactly the block size
// R10 - host changes threshold only between blocks
// R11 - auto fill-in units after transmit fifo empties
// R12 - fill-in units reuse last sequence fields
// R13 - report sapi command bit follows its selector
// R14 - enable bit switches periodic reports on/off
// R15 - host selects hdlc mode before reports
// R16 - crc bytes stripped when forwarding is off
`ifndef HFO_DEFS_SVH
`define HFO_DEFS_SVH
`define HFO_A_FRAME_CFG 8'h00
`define HFO_A_SU_CFG 8'h04
`define HFO_A_MODE 8'h08
`define HFO_A_IRQ_ST 8'h0C
`define HFO_A_IRQ_MASK 8'h10
`define HFO_A_TX_DATA 8'h14
`define HFO_A_RX_DATA 8'h18
`define HFO_A_CMD 8'h1C
`define HFO_A_STATUS 8'h20
`define HFO_FC_RX_CRC 6
`define HFO_FC_TX_CRC 5
`define HFO_FC_IDLE_FLAGS 4
`define HFO_FC_THRESH 1:0
`define HFO_SU_AUTO_FILL 2
`define HFO_SU_CMD_RESP 1
`define HFO_SU_PERF_EN 0
`define HFO_IRQ_POOL_FULL 0
`define HFO_IRQ_RX_END 1
`define HFO_IRQ_TX_DONE 2
`define HFO_IRQ_RX_OVF 3
`define HFO_FLAG 8'h7E
`define HFO_ONES 8'hFF
`define HFO_CRC_INIT 16'hFFFF
`define HFO_CRC_POLY 16'h8408
`define HFO_CRC_GOOD 16'hF0B8
`define HFO_PERF_SAPI 6'h14
`define HFO_PERF_CTRL 8'h03
`define HFO_PERF_PERIOD_S 1
`define HFO_CLK_HZ 125000000
`endif

// File: hw/hfo_pkg.sv
/*
  Types of the HDLC frame options block: bus carriers, transmit states
  and the block's state apart from the fifo memories. Assumes nothing of its surroundings.
*/
package hfo_pkg;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } hfo_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } hfo_wb_rsp_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_OPEN = 3'b001, TX_DATA = 3'b011,
    TX_CRC_LO = 3'b010, TX_CRC_HI = 3'b110
  } hfo_tx_st_t;
  typedef enum logic [1:0] {SRC_HOST = 2'b00, SRC_PERF = 2'b01, SRC_FILL = 2'b11} hfo_src_t;
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [7:0] fcfg;
    logic [7:0] sucfg;
    logic [2:0] mode;
    logic [3:0] irq_st;
    logic [3:0] irq_mask;
    logic [4:0] tx_wp;
    logic [4:0] tx_rp;
    logic [5:0] tx_cnt;
    logic [5:0] tx_frames;
    hfo_tx_st_t tst;
    hfo_src_t tsrc;
    logic [1:0] tidx;
    logic [7:0] tsh;
    logic [3:0] tbits;
    logic tflag;
    logic [2:0] tones;
    logic tstuff;
    logic tlast;
    logic [15:0] tcrc;
    logic tout;
    logic [7:0] seq0;
    logic [7:0] seq1;
    logic fill_ok;
    logic perf_pend;
    logic [26:0] perf_div;
    logic [2:0] rones;
    logic rinf;
    logic rany;
    logic [7:0] rsh;
    logic [2:0] rbits;
    logic [15:0] rcrc;
    logic [7:0] pipe0;
    logic [7:0] pipe1;
    logic [1:0] pcnt;
    logic [7:0] rstat;
    logic [5:0] rx_wp;
    logic [5:0] rx_rp;
    logic [6:0] rx_cnt;
    logic rblk;
  } hfo_state_t;
endpackage

// File: hw/hfo_top.sv
/*
  HDLC frame options block: Wishbone register slave, transmit and
  receive FIFOs, bit-serial HDLC framer with crc, idle fill, fill-in
  units and periodic reports. Assumes bit enables and receive data
  come from framer timeslot logic on clk_i.
*/
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ns
`include "hfo_defs.svh"
module hfo_top #(
  parameter int PERF_PERIOD_CYC = `HFO_PERF_PERIOD_S * `HFO_CLK_HZ
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire hfo_pkg::hfo_wb_req_t wb_i,
  output hfo_pkg::hfo_wb_rsp_t wb_o,
  // serial line, one bit per enable
  input wire logic tx_bit_en_i,
  output logic tx_data_o,
  input wire logic rx_bit_en_i,
  input wire logic rx_data_i,
  // interrupt
  output logic irq_o
);
  import hfo_pkg::*;

  hfo_state_t s;
  hfo_state_t n;
  logic [8:0] tx_mem [32];
  logic [7:0] rx_mem [64];
  logic tx_we;
  logic [8:0] tx_wd;
  logic rx_we;
  logic [7:0] rx_wd;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r >> 1) ^ (((r[0] ^ d[i]) == 1'b1) ? `HFO_CRC_POLY : 16'h0000);
    end
    return r;
  endfunction

  always_comb begin
    logic req;
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic [3:0] set;
    logic [3:0] clr;
    logic [7:0] byte_in;
    logic [7:0] st;
    logic [7:0] fb;
    logic fl;
    logic b;
    logic [6:0] blk;
    n = s;
    req = wb_i.cyc && wb_i.stb && !s.ack;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    set = 4'h0;
    clr = 4'h0;
    byte_in = 8'h00;
    st = 8'h00;
    fb = 8'h00;
    fl = 1'b0;
    b = 1'b0;
    blk = 7'h00;
    tx_we = 1'b0;
    tx_wd = 9'h000;
    rx_we = 1'b0;
    rx_wd = 8'h00;

    // bus slave: ack one cycle after the request, unmapped reads zero
    n.ack = req;
    n.rdat = 32'h0000_0000;
    if (req && wb_i.we && wb_i.sel[0]) begin
      unique case (wb_i.adr)
        `HFO_A_FRAME_CFG: n.fcfg = wb_i.dat[7:0];
        `HFO_A_SU_CFG: n.sucfg = wb_i.dat[7:0];
        `HFO_A_MODE: n.mode = wb_i.dat[2:0];
        `HFO_A_IRQ_ST: clr = wb_i.dat[3:0];
        `HFO_A_IRQ_MASK: n.irq_mask = wb_i.dat[3:0];
        `HFO_A_TX_DATA: begin
          if (s.tx_cnt != 6'd32) begin
            tx_push = 1'b1;
            tx_wd = wb_i.dat[8:0];
          end
        end
        `HFO_A_CMD: begin
          if (wb_i.dat[0]) begin
            n.rblk = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (req && !wb_i.we) begin
      unique case (wb_i.adr)
        `HFO_A_FRAME_CFG: n.rdat = {24'h00_0000, s.fcfg};
        `HFO_A_SU_CFG: n.rdat = {24'h00_0000, s.sucfg};
        `HFO_A_MODE: n.rdat = {29'h0000_0000, s.mode};
        `HFO_A_IRQ_ST: n.rdat = {28'h000_0000, s.irq_st};
        `HFO_A_IRQ_MASK: n.rdat = {28'h000_0000, s.irq_mask};
        `HFO_A_RX_DATA: begin
          if (s.rx_cnt != 7'd0) begin
            rx_pop = 1'b1;
            n.rdat = {23'h00_0000, 1'b1, rx_mem[s.rx_rp]};
          end
        end
        `HFO_A_STATUS: n.rdat = {10'h000, s.tx_cnt, s.rblk, s.rx_cnt, s.rstat};
        default: ;
      endcase
    end

    // transmit bit engine
    if (tx_bit_en_i) begin
      if (s.tstuff) begin
        n.tout = 1'b0;
        n.tstuff = 1'b0;
        n.tones = 3'd0;
      end else begin
        if (s.tbits == 4'd0) begin
          n.tbits = 4'd8;
          n.tflag = 1'b0;
          unique case (s.tst)
            TX_IDLE: begin
              n.tidx = 2'd0;
              n.tcrc = `HFO_CRC_INIT;
              n.tflag = 1'b1;
              n.tsh = `HFO_FLAG;
              n.tst = TX_OPEN;
              if (s.tx_frames != 6'd0) begin
                n.tsrc = SRC_HOST;
              end else if (s.perf_pend) begin
                n.tsrc = SRC_PERF; // see R14
                n.perf_pend = 1'b0;
              end else if (s.sucfg[`HFO_SU_AUTO_FILL] && s.fill_ok && s.tx_cnt == 6'd0) begin
                n.tsrc = SRC_FILL; // see R11
              end else begin
                n.tst = TX_IDLE;
                n.tsh = s.fcfg[`HFO_FC_IDLE_FLAGS] ? `HFO_FLAG : `HFO_ONES; // see R7
              end
            end
            TX_OPEN, TX_DATA: begin
              if (s.tst == TX_DATA && s.tlast) begin
                if (s.tsrc == SRC_HOST && s.fcfg[`HFO_FC_TX_CRC]) begin
                  n.tflag = 1'b1; // see R4
                  n.tsh = `HFO_FLAG; // see R6
                  n.tst = TX_IDLE;
                  set[`HFO_IRQ_TX_DONE] = 1'b1;
                end else begin
                  n.tsh = ~s.tcrc[7:0];
                  n.tst = TX_CRC_LO;
                end
              end else begin
                unique case (s.tsrc)
                  SRC_HOST: begin
                    // in host crc mode the host ends the frame with its own crc bytes
                    {fl, fb} = tx_mem[s.tx_rp]; // see R5
                    tx_pop = 1'b1;
                    if (s.tidx == 2'd0) n.seq0 = fb; // see R12
                    if (s.tidx == 2'd1) n.seq1 = fb; // see R12
                  end
                  SRC_PERF: begin
                    fb = (s.tidx == 2'd0) ?
                      {`HFO_PERF_SAPI, s.sucfg[`HFO_SU_CMD_RESP], 1'b0} : // see R13
                      `HFO_PERF_CTRL;
                    fl = (s.tidx == 2'd1);
                  end
                  default: begin
                    fb = (s.tidx == 2'd0) ? s.seq0 : (s.tidx == 2'd1) ? s.seq1 : 8'h00; // see R12
                    fl = (s.tidx == 2'd2);
                  end
                endcase
                n.tsh = fb;
                n.tlast = fl;
                n.tidx = s.tidx + 2'd1;
                n.tst = TX_DATA;
              end
            end
            TX_CRC_LO: begin
              n.tsh = ~s.tcrc[15:8];
              n.tst = TX_CRC_HI;
            end
            TX_CRC_HI: begin
              n.tflag = 1'b1;
              n.tsh = `HFO_FLAG;
              n.tst = TX_IDLE;
              if (s.tsrc == SRC_HOST) begin
                set[`HFO_IRQ_TX_DONE] = 1'b1;
              end
            end
            default: n.tst = TX_IDLE;
          endcase
          if (n.tst == TX_IDLE && s.tst != TX_IDLE && s.tsrc == SRC_HOST) begin
            n.fill_ok = 1'b1;
          end
        end
        b = n.tsh[0];
        n.tout = b;
        n.tsh = {1'b0, n.tsh[7:1]};
        n.tbits = n.tbits - 4'd1;
        if (n.tflag) begin
          n.tones = 3'd0;
        end else begin
          if (n.tst == TX_DATA) begin
            n.tcrc = (n.tcrc >> 1) ^ (((n.tcrc[0] ^ b) == 1'b1) ? `HFO_CRC_POLY : 16'h0000);
          end
          n.tones = b ? s.tones + 3'd1 : 3'd0;
          n.tstuff = b && s.tones == 3'd4;
        end
      end
    end

    // periodic report timer, after the engine so a new tick beats a take
    if (s.perf_div == 27'(PERF_PERIOD_CYC - 1)) begin
      n.perf_div = 27'd0;
      if (s.sucfg[`HFO_SU_PERF_EN]) begin
        n.perf_pend = 1'b1;
      end
    end else begin
      n.perf_div = s.perf_div + 27'd1;
    end
    if (!s.sucfg[`HFO_SU_PERF_EN]) begin
      n.perf_pend = 1'b0; // see R14
    end

    // receive bit engine
    if (rx_bit_en_i) begin
      b = rx_data_i;
      if (b) begin
        if (s.rones != 3'd7) n.rones = s.rones + 3'd1;
        if (s.rones == 3'd6) begin
          if (s.rinf && s.rany) begin
            rx_push = 1'b1;
            st = 8'h10;
          end
          n.rinf = 1'b0;
        end
      end else begin
        n.rones = 3'd0;
        if (s.rones == 3'd6) begin
          if (s.rinf && s.rany) begin
            st = {s.rbits == 3'd6, 1'b0, s.rcrc == `HFO_CRC_GOOD, 5'h00}; // see R3
            rx_push = 1'b1; // see R2, R16
          end
          n.rinf = 1'b1;
          n.rany = 1'b0;
          n.rbits = 3'd0;
          n.rcrc = `HFO_CRC_INIT;
          n.pcnt = 2'd0; // see R16
        end
      end
      if (s.rones < 3'd5) begin // stuffed zeros and any bit after five ones are dropped
        n.rsh = {b, s.rsh[7:1]};
        n.rbits = s.rbits + 3'd1;
        if (s.rbits == 3'd7 && s.rinf) begin
          byte_in = {b, s.rsh[7:1]};
          n.rany = 1'b1;
          n.rcrc = crc_byte(s.rcrc, byte_in);
          if (s.fcfg[`HFO_FC_RX_CRC]) begin
            rx_push = 1'b1; // see R1
            st = byte_in;
          end else begin
            n.pipe0 = byte_in;
            n.pipe1 = s.pipe0;
            if (s.pcnt == 2'd2) begin
              rx_push = 1'b1;
              st = s.pipe1;
            end else begin
              n.pcnt = s.pcnt + 2'd1;
            end
          end
        end
      end
      if (rx_push && !(s.rones < 3'd5)) begin
        n.rstat = st;
        set[`HFO_IRQ_RX_END] = 1'b1;
      end
    end

    // fifo pointers and counts
    if (tx_push) begin
      tx_we = 1'b1;
      n.tx_wp = s.tx_wp + 5'd1;
    end
    if (tx_pop) begin
      n.tx_rp = s.tx_rp + 5'd1;
    end
    n.tx_cnt = s.tx_cnt + {5'd0, tx_push} - {5'd0, tx_pop};
    n.tx_frames = s.tx_frames + {5'd0, tx_push && tx_wd[8]} - {5'd0, tx_pop && fl};
    if (rx_push && s.rx_cnt == 7'd64) begin
      rx_push = 1'b0;
      set[`HFO_IRQ_RX_OVF] = 1'b1;
    end
    if (rx_push) begin
      rx_we = 1'b1;
      rx_wd = st;
      n.rx_wp = s.rx_wp + 6'd1;
    end
    if (rx_pop) begin
      n.rx_rp = s.rx_rp + 6'd1;
    end
    n.rx_cnt = s.rx_cnt + {6'd0, rx_push} - {6'd0, rx_pop};

    // pool full once per block of the selected size
    unique case (s.fcfg[`HFO_FC_THRESH])
      2'b00: blk = 7'd32; // see R8
      2'b01: blk = 7'd16;
      2'b10: blk = 7'd4;
      default: blk = 7'd2;
    endcase
    if (!n.rblk && n.rx_cnt >= blk) begin
      n.rblk = 1'b1;
      set[`HFO_IRQ_POOL_FULL] = 1'b1; // see R9
    end

    // sticky status, a new event wins over a clear
    n.irq_st = (s.irq_st & ~clr) | set;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.tout <= 1'b1;
    end else begin
      s <= n;
    end
  end

  always_ff @(posedge clk_i) begin
    if (tx_we) begin
      tx_mem[s.tx_wp] <= tx_wd;
    end
    if (rx_we) begin
      rx_mem[s.rx_wp] <= rx_wd;
    end
  end

  assign wb_o = '{ack: s.ack, dat: s.rdat};
  assign tx_data_o = s.tout;
  assign irq_o = |(s.irq_st & s.irq_mask);
endmodule // hfo_top

// File: sim/hfo_checker.sv
/* port assertions for hfo_top.
   assumes one clk_i domain; bound at the foot. */
`timescale 1ns/1ns
`include "hfo_defs.svh"
module hfo_checker #(
  parameter int PERF_PERIOD_CYC = 200
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire hfo_pkg::hfo_wb_req_t wb_i,
  input wire hfo_pkg::hfo_wb_rsp_t wb_o,
  // serial and interrupt
  input wire logic tx_bit_en_i,
  input wire logic tx_data_o,
  input wire logic irq_o
);
  import hfo_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence take_s;
    wb_i.cyc && wb_i.stb && !wb_o.ack;
  endsequence
  sequence mask_off_s;
    take_s ##0 wb_i.we && wb_i.sel[0] && wb_i.adr == `HFO_A_IRQ_MASK && wb_i.dat[3:0] == 4'h0;
  endsequence
  ack_once_a: assert property (take_s |=> wb_o.ack ##1 !wb_o.ack)
    else $error("ack not one pulse after request");
  ack_cause_a: assert property (wb_o.ack |-> $past(wb_i.cyc && wb_i.stb))
    else $error("ack without request");
  write_zero_a: assert property (wb_o.ack && $past(wb_i.we) |-> wb_o.dat == 32'h0000_0000)
    else $error("write answered with data");
  unmapped_read_a: assert property (wb_o.ack && $past(wb_i.adr) > `HFO_A_STATUS |-> wb_o.dat == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (wb_o.ack |-> wb_o.dat[31:22] == 10'h000)
    else $error("upper read bits set");
  mask_off_a: assert property (mask_off_s ##1 wb_o.ack |=> !irq_o)
    else $error("irq high with mask cleared");
  reset_idle_a: assert property (disable iff (1'b0) rst_i |=> tx_data_o && !irq_o && !wb_o.ack)
    else $error("outputs not idle in reset");
  tx_hold_a: assert property ($changed(tx_data_o) |-> $past(tx_bit_en_i))
    else $error("tx bit changed without enable");
endmodule // hfo_checker

bind hfo_top hfo_checker #(.PERF_PERIOD_CYC(PERF_PERIOD_CYC)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
  .tx_bit_en_i(tx_bit_en_i), .tx_data_o(tx_data_o), .irq_o(irq_o));

// File: sim/hfo_peer.sv
/* far hdlc peer: bit slots, frame sender, frame decoder.
   assumes one bit slot every four clk_i cycles. */
`timescale 1ns/1ns
module hfo_peer (
  // clock
  input wire logic clk_i,
  // serial line
  output logic bit_en_o,
  output logic rx_data_o,
  input wire logic tx_data_i
);
  logic [1:0] div_q = 2'h0;
  logic [7:0] acc;
  logic [7:0] cur[$];
  logic [7:0] last[$];
  int nb = 0;
  int ones = 0;
  int flags = 0;
  int frames = 0;
  initial begin
    bit_en_o = 1'b0;
    rx_data_o = 1'b1;
  end
  always @(posedge clk_i) begin
    div_q <= div_q + 2'h1;
    bit_en_o <= (div_q == 2'h3);
  end
  function automatic logic [15:0] crc_fn(logic [7:0] b[$]);
    logic [15:0] c = 16'hFFFF;
    foreach (b[i]) for (int k = 0; k < 8; k++) c = (c >> 1) ^ ((c[0] ^ b[i][k]) ? 16'h8408 : 16'h0);
    return ~c;
  endfunction
  task automatic put_bit(logic b);
    do @(posedge clk_i); while (div_q != 2'h3);
    rx_data_o <= b;
  endtask
  // flag, stuffed bytes with crc low first, flag, idle one
  task automatic send(logic [7:0] d[$], logic bad);
    logic [15:0] c;
    int run;
    c = crc_fn(d) ^ {15'h0, bad};
    d.push_back(c[7:0]);
    d.push_back(c[15:8]);
    run = 0;
    for (int k = 0; k < 8; k++) put_bit(k != 0 && k != 7);
    foreach (d[i]) for (int k = 0; k < 8; k++) begin
      put_bit(d[i][k]);
      run = d[i][k] ? run + 1 : 0;
      if (run == 5) begin
        put_bit(1'b0);
        run = 0;
      end
    end
    for (int k = 0; k < 8; k++) put_bit(k != 0 && k != 7);
    put_bit(1'b1);
  endtask
  // decode transmit line: destuff, flags end frames, long ones abort
  always @(negedge clk_i) if (bit_en_o) begin
    if (tx_data_i) ones++;
    if ((tx_data_i && ones < 6) || (!tx_data_i && ones < 5)) begin
      acc = {tx_data_i, acc[7:1]};
      nb++;
      if (nb == 8) begin
        cur.push_back(acc);
        nb = 0;
      end
    end
    if (!tx_data_i) begin
      if (ones == 6) flags++;
      if (ones == 6 && cur.size() > 0) begin
        last = cur;
        frames++;
      end
      if (ones >= 6) begin
        cur = {};
        nb = 0;
      end
      ones = 0;
    end
  end
endmodule // hfo_peer

// File: sim/hdlc_channel_frame_options_bench.sv
/* bench for hfo_top: bus tasks, peer traffic, checks.
   assumes hfo_peer and the bound checker. */
`timescale 1ns/1ns
`include "hfo_defs.svh"
module hdlc_channel_frame_options_bench;
  import hfo_pkg::*;
  localparam logic [7:0] FC = `HFO_A_FRAME_CFG, SU = `HFO_A_SU_CFG, IS = `HFO_A_IRQ_ST;
  localparam logic [7:0] IM = `HFO_A_IRQ_MASK, RX = `HFO_A_RX_DATA, ST = `HFO_A_STATUS;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic en, rxd, txd, irq_o;
  hfo_wb_req_t wb_i = '0;
  hfo_wb_rsp_t wb_o;
  int bad_count = 0;
  int comparisons = 0;
  int n;
  logic [15:0] k;
  logic [31:0] rd;
  logic [7:0] e[$];
  logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h24};
  always #4 clk_i = ~clk_i;
  hfo_top #(.PERF_PERIOD_CYC(200)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
    .wb_o(wb_o), .tx_bit_en_i(en), .tx_data_o(txd), .rx_bit_en_i(en), .rx_data_i(rxd),
    .irq_o(irq_o));
  hfo_peer u_peer (.clk_i(clk_i), .bit_en_o(en), .rx_data_o(rxd), .tx_data_i(txd));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic hang(int t);
    if (t > 5000) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  task automatic check(string w, logic [31:0] x, logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", w, x, g);
    end
  endtask
  task automatic check_frame();
    check("frame length", e.size(), u_peer.last.size());
    foreach (e[i]) check("frame byte", e[i], u_peer.last[i]);
  endtask
  task automatic wb(logic we, logic [7:0] a, logic [31:0] d);
    int t = 0;
    @(posedge clk_i);
    wb_i <= '{1'b1, 1'b1, we, a, 4'hF, d};
    do begin
      @(posedge clk_i);
      hang(t++);
    end while (wb_o.ack !== 1'b1);
    rd = wb_o.dat;
    wb_i <= '0;
  endtask
  task automatic wrchk(logic [7:0] a, logic [31:0] d);
    wb(1'b1, a, d);
    wb(1'b0, a, 32'h0);
    check("register", d, rd);
  endtask
  task automatic add_crc(logic f);
    k = u_peer.crc_fn(e) ^ {15'h0, f};
    e.push_back(k[7:0]);
    e.push_back(k[15:8]);
  endtask
  task automatic wait_frames(int m);
    int t = 0;
    int goal = u_peer.frames + m;
    while (u_peer.frames < goal) begin
      @(posedge clk_i);
      hang(t++);
    end
  endtask
  task automatic txf(int m);
    foreach (e[i]) wb(1'b1, `HFO_A_TX_DATA, {23'h0, i == e.size() - 1, e[i]});
    wait_frames(m);
  endtask
  task automatic quiet();
    repeat (300) @(posedge clk_i);
    n = u_peer.frames;
    repeat (500) @(posedge clk_i);
    check("no frames", n, u_peer.frames);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ra[i]) begin
      wb(1'b0, ra[i], 32'h0);
      check("reset value", 32'h0, rd);
    end
    wrchk(FC, 32'h7B);
    wrchk(SU, 32'h6);
    wrchk(`HFO_A_MODE, 32'h4);
    wb(1'b1, SU, 32'h0);
    for (int c = 0; c < 3; c++) begin
      wb(1'b1, FC, c == 2 ? 32'h3 : (c == 1 ? 32'h42 : 32'h43));
      wb(1'b1, `HFO_A_CMD, 32'h1);
      wb(1'b1, IS, 32'hF);
      wb(1'b1, IM, 32'h1);
      e = '{8'h81, 8'h3F, 8'hFE, 8'h42};
      fork
        u_peer.send(e, c == 1);
        begin
          n = 0;
          while (irq_o !== 1'b1) begin
            @(posedge clk_i);
            hang(n++);
          end
          wb(1'b0, ST, 32'h0);
          check("block count", c == 1 ? 32'h4 : 32'h2, {25'h0, rd[14:8]});
          wb(1'b1, IM, 32'h0);
          @(posedge clk_i);
          check("masked irq", 32'h0, {31'h0, irq_o});
          wb(1'b1, IM, 32'h1);
          @(posedge clk_i);
          check("unmasked irq", 32'h1, {31'h0, irq_o});
        end
      join
      n = 0;
      do begin
        wb(1'b0, IS, 32'h0);
        hang(n++);
      end while (rd[1] !== 1'b1);
      if (c < 2) add_crc(c == 1);
      e.push_back(c == 1 ? 8'h80 : 8'hA0);
      foreach (e[i]) begin
        wb(1'b0, RX, 32'h0);
        check("rx fifo", {23'h0, 1'b1, e[i]}, rd);
      end
      wb(1'b0, RX, 32'h0);
      check("rx empty", 32'h0, rd);
      wb(1'b1, IS, 32'hF);
      @(posedge clk_i);
      check("cleared irq", 32'h0, {31'h0, irq_o});
    end
    wb(1'b1, FC, 32'h0);
    n = u_peer.flags;
    repeat (200) @(posedge clk_i);
    check("ones fill", n, u_peer.flags);
    wb(1'b1, FC, 32'h10);
    repeat (200) @(posedge clk_i);
    check("flag fill", 32'h1, {31'h0, u_peer.flags > n + 3});
    e = '{8'h11, 8'h22, 8'h33};
    txf(1);
    add_crc(1'b0);
    check_frame();
    wb(1'b1, FC, 32'h30);
    e = '{8'h11, 8'h22};
    add_crc(1'b0);
    txf(1);
    check_frame();
    wb(1'b1, FC, 32'h10);
    e = '{8'hA5, 8'h5A, 8'h01};
    txf(0);
    // enable fill once the host frame is queued, so a fill unit cannot go first
    wb(1'b1, SU, 32'h4);
    wait_frames(2);
    e = '{8'hA5, 8'h5A, 8'h00};
    add_crc(1'b0);
    check_frame();
    wb(1'b1, SU, 32'h0);
    quiet();
    for (int c = 0; c < 2; c++) begin
      wb(1'b1, SU, 32'h1 | (c << 1));
      wait_frames(2);
      e = '{{6'h14, c[0], 1'b0}, 8'h03};
      add_crc(1'b0);
      check_frame();
    end
    wb(1'b1, SU, 32'h0);
    quiet();
    report_and_stop();
  end
endmodule // hdlc_channel_frame_options_bench
